// [dv/pmf_host.sv]
// Host software model issuing register requests and fault stimulus
`timescale 1ns/1ps
module pmf_host
	import pmf_pkg::*;
(
	input wire logic clk_sys,
	output pmf_addr_t regAddr,
	output logic regWr,
	output logic regRd,
	output pmf_byte_t regWrData,
	output logic [7:0] side
);
	initial {regAddr, regWr, regRd, regWrData, side} = '0;
	task automatic op(logic w, logic r, pmf_addr_t a, pmf_byte_t d, logic [7:0] s);
		{regWr, regRd, regAddr, regWrData, side} = {w, r, a, d, s};
		@(negedge clk_sys);
	endtask
endmodule

// [dv/pmf_regs_chk.sv]
// Port assertions for the mode and fault registers
`timescale 1ns/1ps
`include "pmf_consts.svh"
module pmf_regs_chk
	import pmf_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire pmf_addr_t regAddr,
	input wire logic regWr,
	input wire logic regRd,
	input wire pmf_byte_t regWrData,
	input wire pmf_byte_t regRdData,
	input wire logic regRdValid,
	input wire logic laneFifoClear
);
	wire clrWr = regWr && regAddr == `PMF_OFS_FLAGS && regWrData[`PMF_BIT_FIFO];
	wire mapped = regAddr inside {`PMF_OFS_MODE_TWO, `PMF_OFS_MODE_THREE, `PMF_OFS_MODE_FOUR, `PMF_OFS_SUMMARY,
		`PMF_OFS_FLAGS, `PMF_OFS_MASK};
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	sequence maskWrRd;
		regWr && regAddr == `PMF_OFS_MASK ##1 regRd && regAddr == `PMF_OFS_MASK;
	endsequence
	a_rd_next: assert property (regRd |=> regRdValid) else $error("late read");
	a_rd_lone: assert property (!regRd |=> !regRdValid) else $error("stray read");
	a_idle_zero: assert property (!regRd |=> regRdData == 8'h00) else $error("stray read data");
	a_mask_kept: assert property (maskWrRd |=> regRdData == $past(regWrData, 2)) else $error("mask");
	a_sum_upper: assert property (regRd && regAddr == `PMF_OFS_SUMMARY |=> regRdData[7:1] == 7'h00)
		else $error("summary");
	a_flag_upper: assert property (regRd && regAddr == `PMF_OFS_FLAGS |=> regRdData[7:6] == 2'h0)
		else $error("flags");
	a_unmapped_zero: assert property (regRd && !mapped |=> regRdData == 8'h00) else $error("unmapped");
	a_clr_pulse: assert property (clrWr |=> laneFifoClear) else $error("no clear");
	a_clr_only: assert property (!clrWr |=> !laneFifoClear) else $error("stray clear");
endmodule
bind pmf_regs pmf_regs_chk pmf_regs_chk_i (.*);

// [dv/testbench.sv]
// Bench with a reference model of the registers
`timescale 1ns/1ps
module testbench
	import pmf_pkg::*;
();
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic softReset, regWr, regRd, regRdValid, divMismatch, linkFault, realignEvent, serPllUnlocked, pn, lc;
	logic laneFifoError, calStatusSel, calDone, calibrationStatusPin, lowPowerActive, laneFifoClear;
	pmf_addr_t regAddr;
	pmf_byte_t regWrData, regRdData, powerCodeTwo, powerCodeThree, powerCodeFour, ex;
	logic [7:0] side;
	logic lp;
	logic [7:0] rs;
	int failCount = 0, numChecks = 0, seed = 65, i, rk;
	int m[6] = '{8'h0F, 8'h04, 8'h1B, 0, 8'h3F, 8'h3F};
	int lo[8] = '{8'h06, 8'h00, 8'h14, 0, 8'h0F, 8'h04, 8'h1B, 0};
	assign {calDone, calStatusSel, softReset, laneFifoError, serPllUnlocked, linkFault, realignEvent, divMismatch} = side;
	always #2.5 clk_sys = ~clk_sys;
	pmf_regs pmf_regs_i (.*);
	pmf_host pmf_host_i (.*);
	task automatic chk(string n, logic [15:0] e, logic [15:0] g);
		numChecks++;
		if (g !== e) begin
			failCount++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	// Model reads old state first: a read in the write cycle returns the old value
	task automatic step(logic w, logic r, int k, logic [7:0] d, logic [7:0] s);
		ex = r && k < 6 ? m[k][7:0] : 8'h00;
		pn = s[6] ? m[3][0] : s[7];
		lc = w && k == 4 && d[5];
		lp = m[0] == 8'h06 && m[1] == 8'h00 && m[2] == 8'h14;
		m[3] = |(m[4] & ~m[5] & 8'h3F);
		m[4] = ((w && k == 4 ? m[4] & ~d : m[4]) | (s[5] ? 8'h3F : {s[4:1], 1'b0, s[0]})) & 8'h3F;
		if (w && k != 3 && k != 4 && k < 6) m[k] = d;
		pmf_host_i.op(w, r, k < 3 ? 15'h029A + k[14:0] : 15'h02BD + k[14:0], d, s);
		chk("outputs", {ex, r, pn, lc}, {regRdData, regRdValid, calibrationStatusPin, laneFifoClear});
		chk("mode two", m[0][7:0], powerCodeTwo);
		chk("mode three", m[1][7:0], powerCodeThree);
		chk("mode four", m[2][7:0], powerCodeFour);
		chk("low power state", lp, lowPowerActive);
	endtask
	initial begin
		repeat (2) @(negedge clk_sys);
		rst_n = 1'b1;
		for (i = 0; i < 7; i++) step(0, 1, i, 0, 0);
		$display("reset done");
		for (i = 0; i < 8; i++) begin
			step(i % 4 != 3, 1, i % 4, lo[i], 0);
			if (i % 4 == 3) chk("low power", i < 4, lowPowerActive);
		end
		$display("mode done");
		for (i = 0; i < 1500; i++) begin
			rk = 3 + $unsigned($random(seed)) % 4;
			rs = $random(seed) & $random(seed) & $random(seed);
			step($random(seed), $random(seed), rk, $random(seed), rs);
		end
		$display("random done");
		rst_n = 1'b0;
		@(negedge clk_sys);
		rst_n = 1'b1;
		m = '{8'h0F, 8'h04, 8'h1B, 0, 8'h3F, 8'h3F};
		for (i = 0; i < 7; i++) step(0, 1, i, 0, 0);
		$display("second reset done");
		endSim;
	end
	task endSim;
		$display("checks %0d fails %0d", numChecks, failCount);
		if (failCount == 0 && numChecks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
endmodule

// [hdl/pmf_consts.svh]
// Offsets, field positions, reset values and codes of the power-mode and fault registers
`ifndef PMF_CONSTS_SVH
`define PMF_CONSTS_SVH

`define PMF_ADDR_W 15
`define PMF_OFS_MODE_TWO 15'h029A
`define PMF_OFS_MODE_THREE 15'h029B
`define PMF_OFS_MODE_FOUR 15'h029C
`define PMF_OFS_SUMMARY 15'h02C0
`define PMF_OFS_FLAGS 15'h02C1
`define PMF_OFS_MASK 15'h02C2

`define PMF_CODE_TWO_LOW 8'h06
`define PMF_CODE_TWO_HIGH 8'h0F
`define PMF_CODE_THREE_LOW 8'h00
`define PMF_CODE_THREE_HIGH 8'h04
`define PMF_CODE_FOUR_LOW 8'h14
`define PMF_CODE_FOUR_HIGH 8'h1B

`define PMF_NUM_FLAGS 6
`define PMF_FLAGS_RESET 6'h3F
`define PMF_MASK_RESET 8'h3F
`define PMF_SUMMARY_RESET 1'h0
`define PMF_BIT_CLK 0
`define PMF_BIT_REALIGN 2
`define PMF_BIT_LINK 3
`define PMF_BIT_SPLL 4
`define PMF_BIT_FIFO 5

`endif

// [hdl/pmf_fault_flags.sv]
// Next value of the sticky write-one-to-clear fault flags
`timescale 1ns/1ps
`include "pmf_consts.svh"
module pmf_fault_flags
	import pmf_pkg::*;
(
	input wire pmf_flags_t flagsCur,
	input wire pmf_flags_t faultSet,
	input wire pmf_flags_t clearBits,
	input wire logic softReset,
	output pmf_flags_t flagsNxt
);
	// Per-bit drivers land on a net so the output port keeps a single driver
	wire pmf_flags_t nxtBits;
	genvar i;
	generate
		for (i = 0; i < `PMF_NUM_FLAGS; i = i + 1) begin : gFlag
			assign nxtBits[i] = softReset | faultSet[i] | (flagsCur[i] & ~clearBits[i]);
		end
	endgenerate
	assign flagsNxt = nxtBits;
endmodule

// [hdl/pmf_pkg.sv]
// Types shared by the power-mode and fault register logic
`include "pmf_consts.svh"
package pmf_pkg;
	typedef logic [7:0] pmf_byte_t;
	typedef logic [`PMF_NUM_FLAGS-1:0] pmf_flags_t;
	typedef logic [`PMF_ADDR_W-1:0] pmf_addr_t;

	typedef struct packed {
		pmf_byte_t modeTwo;
		pmf_byte_t modeThree;
		pmf_byte_t modeFour;
		pmf_byte_t mask;
		pmf_flags_t flags;
		logic summary;
		logic calPin;
		logic lowPower;
		pmf_byte_t rdData;
		logic rdValid;
		logic laneClr;
	} pmf_state_t;
endpackage

// [hdl/pmf_regs.sv]
// Power-mode selection registers and fault flag aggregation
// Notes on behaviour
// - Mode two register: 0x06 reduced power, 0x0F high performance, resets high.
// - Mode three register: 0x00 reduced power, 0x04 high performance, resets high.
// - Mode four register: 0x14 reduced power, 0x1B high performance, resets high.
// - Other mode codes are reserved; stored as written, effect undefined.
// - Summary bit 0 is one when any unmasked flag is set; resets zero.
// - Select input routes summary onto calibration status pin as interrupt.
// - Fault flags reset to 0x3F; cleared by writes, never by reads.
// - Bit 5 sets on lane FIFO overflow or underflow; write one clears.
// - Mask bit one keeps matching flag out of summary; mask resets 0x3F.
// - Bit 4 sets while serializer PLL is unlocked; write one clears.
// - Bit 2 sets when reference input realigns internal clocks; write one clears.
// - Power-on or software reset sets every fault flag.
`timescale 1ns/1ps
`include "pmf_consts.svh"
module pmf_regs
	import pmf_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic softReset,
	input wire pmf_addr_t regAddr,
	input wire logic regWr,
	input wire logic regRd,
	input wire pmf_byte_t regWrData,
	output pmf_byte_t regRdData,
	output logic regRdValid,
	input wire logic divMismatch,
	input wire logic linkFault,
	input wire logic realignEvent,
	input wire logic serPllUnlocked,
	input wire logic laneFifoError,
	input wire logic calStatusSel,
	input wire logic calDone,
	output logic calibrationStatusPin,
	output pmf_byte_t powerCodeTwo,
	output pmf_byte_t powerCodeThree,
	output pmf_byte_t powerCodeFour,
	output logic lowPowerActive,
	output logic laneFifoClear
);
	pmf_state_t st_r;
	pmf_state_t st_nxt;
	pmf_flags_t faultSet;
	pmf_flags_t clearBits;
	pmf_flags_t flagsNxt;
	logic wrFlags;

	assign faultSet = {laneFifoError, serPllUnlocked, linkFault, realignEvent, 1'b0, divMismatch};

	assign wrFlags = regWr && (regAddr == `PMF_OFS_FLAGS);
	assign clearBits = wrFlags ? regWrData[`PMF_NUM_FLAGS-1:0] : '0;

	pmf_fault_flags uFlags (
		.flagsCur(st_r.flags),
		.faultSet(faultSet),
		.clearBits(clearBits),
		.softReset(softReset),
		.flagsNxt(flagsNxt)
	);

	always_comb begin
		st_nxt = st_r;
		st_nxt.flags = flagsNxt;
		st_nxt.rdValid = regRd;
		st_nxt.laneClr = wrFlags && regWrData[`PMF_BIT_FIFO];
		if (regWr) begin
			unique case (regAddr)
				`PMF_OFS_MODE_TWO: begin
					st_nxt.modeTwo = regWrData;
				end
				`PMF_OFS_MODE_THREE: begin
					st_nxt.modeThree = regWrData;
				end
				`PMF_OFS_MODE_FOUR: begin
					st_nxt.modeFour = regWrData;
				end
				`PMF_OFS_MASK: begin
					st_nxt.mask = regWrData;
				end
				default: begin
				end
			endcase
		end
		// One clock behind flags and mask
		st_nxt.summary = |(st_r.flags & ~st_r.mask[`PMF_NUM_FLAGS-1:0]);
		st_nxt.calPin = calStatusSel ? st_r.summary : calDone;
		// Mixed codes count as high performance, the safer reading
		st_nxt.lowPower = (st_r.modeTwo == `PMF_CODE_TWO_LOW) && (st_r.modeThree == `PMF_CODE_THREE_LOW)
			&& (st_r.modeFour == `PMF_CODE_FOUR_LOW);
		st_nxt.rdData = 8'h00;
		if (regRd) begin
			unique case (regAddr)
				`PMF_OFS_MODE_TWO: begin
					st_nxt.rdData = st_r.modeTwo;
				end
				`PMF_OFS_MODE_THREE: begin
					st_nxt.rdData = st_r.modeThree;
				end
				`PMF_OFS_MODE_FOUR: begin
					st_nxt.rdData = st_r.modeFour;
				end
				`PMF_OFS_SUMMARY: begin
					st_nxt.rdData = {7'h00, st_r.summary};
				end
				`PMF_OFS_FLAGS: begin
					st_nxt.rdData = {2'h0, st_r.flags};
				end
				`PMF_OFS_MASK: begin
					st_nxt.rdData = st_r.mask;
				end
				default: begin
					st_nxt.rdData = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_r.modeTwo <= `PMF_CODE_TWO_HIGH;
			st_r.modeThree <= `PMF_CODE_THREE_HIGH;
			st_r.modeFour <= `PMF_CODE_FOUR_HIGH;
			st_r.mask <= `PMF_MASK_RESET;
			st_r.flags <= `PMF_FLAGS_RESET;
			st_r.summary <= `PMF_SUMMARY_RESET;
			st_r.calPin <= 1'b0;
			st_r.lowPower <= 1'b0;
			st_r.rdData <= 8'h00;
			st_r.rdValid <= 1'b0;
			st_r.laneClr <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign regRdData = st_r.rdData;
	assign regRdValid = st_r.rdValid;
	assign calibrationStatusPin = st_r.calPin;
	assign powerCodeTwo = st_r.modeTwo;
	assign powerCodeThree = st_r.modeThree;
	assign powerCodeFour = st_r.modeFour;
	assign lowPowerActive = st_r.lowPower;
	assign laneFifoClear = st_r.laneClr;
endmodule
